/* File: hw/psam_defs.svh */
// Register offsets, field positions, reset values and key values of the program space mapper
`ifndef PSAM_DEFS_SVH
`define PSAM_DEFS_SVH

`define PSAM_OFS_TBL_PAGE   12'h000
`define PSAM_OFS_VIS_PAGE   12'h004
`define PSAM_OFS_KEY        12'h008
`define PSAM_OFS_CTL        12'h00C
`define PSAM_OFS_STAT       12'h010

`define PSAM_RST_TBL_PAGE   8'h00
`define PSAM_RST_VIS_PAGE   8'h00

`define PSAM_KEY_FIRST      8'h55
`define PSAM_KEY_SECOND     8'hAA

`define PSAM_CTL_START_BIT  0
`define PSAM_CTL_ARMED_BIT  1
`define PSAM_STAT_PSVW_BIT  0
`define PSAM_STAT_STRF_BIT  1

`define PSAM_PAGE_CFG_BIT   7
`define PSAM_EA_WIN_BIT     15
`define PSAM_FILE_AW        13

`endif

/* File: hw/psam_pkg.sv */
// Types shared by the program space mapper
package psam_pkg;

    typedef enum logic [2:0] {
        PSAM_OP_DATA  = 3'h0,
        PSAM_OP_FILE  = 3'h1,
        PSAM_OP_TRD_L = 3'h2,
        PSAM_OP_TRD_H = 3'h3,
        PSAM_OP_TWR_L = 3'h4,
        PSAM_OP_TWR_H = 3'h5
    } psam_op_type;

    typedef enum logic [2:0] {
        PSAM_KEY_IDLE  = 3'b001,
        PSAM_KEY_GOT1  = 3'b010,
        PSAM_KEY_ARMED = 3'b100
    } psam_key_type;

    typedef struct packed {
        logic        valid;
        psam_op_type op;
        logic        write;
        logic        byte_mode;
        logic [15:0] ea;
        logic [15:0] wdata;
    } psam_req_type;

    typedef struct packed {
        logic        rd_en;
        logic        cfg_sel;
        logic [23:0] addr;
    } psam_prog_type;

    typedef struct packed {
        logic [2:0]  be;
        logic [23:0] addr;
        logic [23:0] data;
    } psam_latch_type;

    typedef struct packed {
        logic        en;
        logic        write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } psam_dmem_type;

endpackage

/* File: hw/psam_top.sv */
// Program space mapper: address building, table latch writes, unlock sequence, APB registers
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "psam_defs.svh"

module psam_top
    import psam_pkg::*;
#(
    parameter int PC_W = 23                 // Program counter width
) (
    input  wire logic           core_clk,      // Instruction clock
    input  wire logic           rst_b,         // Synchronous reset, active low
    input  wire logic           psel,          // APB select
    input  wire logic           penable,       // APB access phase
    input  wire logic           pwrite,        // APB direction
    input  wire logic [11:0]    paddr,         // APB byte address
    input  wire logic [31:0]    pwdata,        // APB write data
    output logic                pready,        // APB ready
    output logic [31:0]         prdata,        // APB read data
    output logic                pslverr,       // APB error
    input  wire logic           fetch_valid,   // Fetch request
    input  wire logic [PC_W-1:0] fetch_pc,     // Program counter
    output logic [23:0]         fetch_addr,    // Fetch program address
    output logic                fetch_rd_en,   // Fetch strobe
    input  wire psam_req_type   core_req,      // Data-space request
    output psam_prog_type       prog_out,      // Program read port
    input  wire logic [23:0]    prog_rdata,    // Program word read back
    output psam_latch_type      latch_out,     // Program latch write
    output psam_dmem_type       dmem_out,      // Ordinary data memory access
    output logic                rsp_valid,     // Program read answer valid
    output logic [15:0]         rsp_data,      // Program read answer
    output logic                flash_start,   // Start pulse to flash array
    input  wire logic           flash_done     // Flash operation finished
);

    // Page registers, unlock state and fault flags
    logic [7:0]   tbl_page_r;
    logic [7:0]   vis_page_r;
    psam_key_type key_r;
    logic         busy_r;
    logic         psvw_err_r;
    logic         strf_err_r;

    // APB answer flops
    logic         pready_r;
    logic [31:0]  prdata_r;
    logic         pslverr_r;

    // Flopped outputs toward fetch, program array, latches and data memory
    logic [23:0]  fetch_addr_r;
    logic         fetch_rd_r;
    psam_prog_type  prog_r;
    psam_latch_type latch_r;
    psam_dmem_type  dmem_r;
    logic         rsp_valid_r;
    logic [15:0]  rsp_data_r;
    logic         start_r;

    // Pending read bookkeeping for the answer stage
    psam_op_type  pend_op_r;
    logic         pend_rd_r;
    logic         pend_byte_r;
    logic         pend_odd_r;

    // Decoded strobes of the current cycle
    logic         apb_done;
    logic         apb_wr;
    logic         mapped;
    logic         wr_key;
    logic         wr_start;
    logic         stat_clr_psvw;
    logic         stat_clr_strf;
    logic         psvw_evt;
    logic         strf_evt;
    logic         win_hit;

    // APB decode; a transfer completes at the edge where pready_r is high
    assign apb_done = psel & penable & pready_r;
    assign apb_wr   = apb_done & pwrite;
    assign mapped   = (paddr == `PSAM_OFS_TBL_PAGE) || (paddr == `PSAM_OFS_VIS_PAGE) ||
                      (paddr == `PSAM_OFS_KEY) || (paddr == `PSAM_OFS_CTL) ||
                      (paddr == `PSAM_OFS_STAT);
    assign wr_key   = apb_wr & (paddr == `PSAM_OFS_KEY);
    assign wr_start = apb_wr & (paddr == `PSAM_OFS_CTL) & pwdata[`PSAM_CTL_START_BIT];
    assign stat_clr_psvw = apb_wr & (paddr == `PSAM_OFS_STAT) & pwdata[`PSAM_STAT_PSVW_BIT];
    assign stat_clr_strf = apb_wr & (paddr == `PSAM_OFS_STAT) & pwdata[`PSAM_STAT_STRF_BIT];

    // Window decode of a data request
    assign win_hit  = core_req.valid & (core_req.op == PSAM_OP_DATA) &
                      core_req.ea[`PSAM_EA_WIN_BIT];
    assign psvw_evt = win_hit & core_req.write;
    assign strf_evt = wr_start & (key_r != PSAM_KEY_ARMED);

    // APB handshake: one wait cycle so read data comes from a flop
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else if (psel & penable & !pready_r) begin
            pready_r  <= 1'b1;
            // Unmapped offsets answer with an error and read zero
            pslverr_r <= !mapped;
            case (paddr)
                `PSAM_OFS_TBL_PAGE: prdata_r <= {24'h000000, tbl_page_r};
                `PSAM_OFS_VIS_PAGE: prdata_r <= {24'h000000, vis_page_r};
                `PSAM_OFS_CTL:      prdata_r <= {30'h00000000, (key_r == PSAM_KEY_ARMED), busy_r};
                `PSAM_OFS_STAT:     prdata_r <= {30'h00000000, strf_err_r, psvw_err_r};
                default:            prdata_r <= 32'h00000000;
            endcase
        end else begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end
    end

    // Page registers
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            tbl_page_r <= `PSAM_RST_TBL_PAGE;
            vis_page_r <= `PSAM_RST_VIS_PAGE;
        end else begin
            if (apb_wr && paddr == `PSAM_OFS_TBL_PAGE) begin
                tbl_page_r <= pwdata[7:0];
            end
            if (apb_wr && paddr == `PSAM_OFS_VIS_PAGE) begin
                vis_page_r <= pwdata[7:0];
            end
        end
    end

    // Unlock sequence; interrupt blocking around it is left to software
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            key_r <= PSAM_KEY_IDLE;
        end else if (wr_key) begin
            // A wrong key drops back to idle, so the pair must come in order
            case (key_r)
                PSAM_KEY_IDLE:  key_r <= (pwdata[7:0] == `PSAM_KEY_FIRST) ?
                                         PSAM_KEY_GOT1 : PSAM_KEY_IDLE;
                PSAM_KEY_GOT1:  key_r <= (pwdata[7:0] == `PSAM_KEY_SECOND) ?
                                         PSAM_KEY_ARMED : PSAM_KEY_IDLE;
                default:        key_r <= PSAM_KEY_IDLE;
            endcase
        end else if (wr_start) begin
            key_r <= PSAM_KEY_IDLE;
        end
    end

    // Start pulse and busy flag; start only honoured when armed
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            start_r <= 1'b0;
            busy_r  <= 1'b0;
        end else begin
            start_r <= wr_start & (key_r == PSAM_KEY_ARMED) & !busy_r;
            if (wr_start & (key_r == PSAM_KEY_ARMED)) begin
                busy_r <= 1'b1;
            end else if (flash_done) begin
                busy_r <= 1'b0;
            end
        end
    end

    // Sticky fault flags; a new event wins over a clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            psvw_err_r <= 1'b0;
            strf_err_r <= 1'b0;
        end else begin
            // Software clears a flag by writing a one to it
            psvw_err_r <= psvw_evt | (psvw_err_r & !stat_clr_psvw);
            strf_err_r <= strf_evt | (strf_err_r & !stat_clr_strf);
        end
    end

    // Instruction fetch address
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            fetch_addr_r <= 24'h000000;
            fetch_rd_r   <= 1'b0;
        end else begin
            fetch_rd_r   <= fetch_valid;
            fetch_addr_r <= {1'b0, fetch_pc[22:1], 1'b0};
        end
    end

    // Program read port: table reads and window reads
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            prog_r <= '0;
        end else begin
            prog_r.rd_en <= 1'b0;
            if (core_req.valid &&
                (core_req.op == PSAM_OP_TRD_L || core_req.op == PSAM_OP_TRD_H)) begin
                prog_r.rd_en   <= 1'b1;
                prog_r.addr    <= {tbl_page_r, core_req.ea};
                prog_r.cfg_sel <= tbl_page_r[`PSAM_PAGE_CFG_BIT];
            end else if (win_hit && !core_req.write) begin
                prog_r.rd_en   <= 1'b1;
                // Bit 15 of the address comes from page bit 0, not from the EA
                prog_r.addr    <= {1'b0, vis_page_r, core_req.ea[14:0]};
                prog_r.cfg_sel <= 1'b0;
            end
        end
    end

    // Program latch writes, byte lanes {upper, middle, low}
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            latch_r <= '0;
        end else begin
            latch_r.be <= 3'h0;
            // Low word write fills two lanes; a byte write picks one lane by ea[0]
            if (core_req.valid && core_req.op == PSAM_OP_TWR_L) begin
                latch_r.addr <= {tbl_page_r, core_req.ea};
                if (core_req.byte_mode) begin
                    latch_r.be   <= core_req.ea[0] ? 3'h2 : 3'h1;
                    latch_r.data <= {8'h00, core_req.wdata[7:0], core_req.wdata[7:0]};
                end else begin
                    latch_r.be   <= 3'h3;
                    latch_r.data <= {8'h00, core_req.wdata};
                end
            end else if (core_req.valid && core_req.op == PSAM_OP_TWR_H) begin
                latch_r.addr <= {tbl_page_r, core_req.ea};
                // Odd byte of the high word is the phantom byte and is dropped
                latch_r.be   <= (core_req.byte_mode & core_req.ea[0]) ? 3'h0 : 3'h4;
                latch_r.data <= {core_req.wdata[7:0], 16'h0000};
            end
        end
    end

    // Ordinary data memory routing: direct file field and low-half EAs
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            dmem_r <= '0;
        end else begin
            dmem_r.en <= 1'b0;
            // File accesses keep only the near field; higher address bits are dropped
            if (core_req.valid && core_req.op == PSAM_OP_FILE) begin
                dmem_r.en    <= 1'b1;
                dmem_r.write <= core_req.write;
                dmem_r.addr  <= {3'h0, core_req.ea[`PSAM_FILE_AW-1:0]};
                dmem_r.wdata <= core_req.wdata;
            end else if (core_req.valid && core_req.op == PSAM_OP_DATA &&
                         !core_req.ea[`PSAM_EA_WIN_BIT]) begin
                dmem_r.en    <= 1'b1;
                dmem_r.write <= core_req.write;
                dmem_r.addr  <= core_req.ea;
                dmem_r.wdata <= core_req.wdata;
            end
        end
    end

    // Remember what the pending program read was for the answer stage
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pend_op_r   <= PSAM_OP_DATA;
            pend_rd_r   <= 1'b0;
            pend_byte_r <= 1'b0;
            pend_odd_r  <= 1'b0;
        end else begin
            pend_rd_r   <= (core_req.valid &&
                            (core_req.op == PSAM_OP_TRD_L || core_req.op == PSAM_OP_TRD_H)) ||
                           (win_hit && !core_req.write);
            pend_op_r   <= core_req.op;
            pend_byte_r <= core_req.byte_mode;
            pend_odd_r  <= core_req.ea[0];
        end
    end

    // Answer stage: select word or byte from the returned program word
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rsp_valid_r <= 1'b0;
            rsp_data_r  <= 16'h0000;
        end else begin
            rsp_valid_r <= pend_rd_r;
            // The upper byte is reachable through table reads only
            case (pend_op_r)
                PSAM_OP_TRD_H: rsp_data_r <= (pend_byte_r & pend_odd_r) ? 16'h0000 :
                                             {8'h00, prog_rdata[23:16]};
                PSAM_OP_TRD_L: rsp_data_r <= !pend_byte_r ? prog_rdata[15:0] :
                                             pend_odd_r ? {8'h00, prog_rdata[15:8]} :
                                             {8'h00, prog_rdata[7:0]};
                default:       rsp_data_r <= prog_rdata[15:0];
            endcase
        end
    end

    // Every output is a flop copy; no logic after the registers
    assign pready      = pready_r;
    assign prdata      = prdata_r;
    assign pslverr     = pslverr_r;
    assign fetch_addr  = fetch_addr_r;
    assign fetch_rd_en = fetch_rd_r;
    assign prog_out    = prog_r;
    assign latch_out   = latch_r;
    assign dmem_out    = dmem_r;
    assign rsp_valid   = rsp_valid_r;
    assign rsp_data    = rsp_data_r;
    assign flash_start = start_r;

endmodule // psam_top

`default_nettype wire

/* File: tb/psam_flash_model.sv */
// Program flash array model: combinational word read, delayed operation finish
`timescale 1ns/1ps
`default_nettype none
module psam_flash_model
    import psam_pkg::*;
#(
    parameter int DONE_DLY = 20              // Cycles from start to finish
) (
    input  wire logic          core_clk,     // Clock
    input  wire psam_prog_type prog_out,     // Read request
    output logic [23:0]        prog_rdata,   // Word read back
    input  wire logic          flash_start,  // Operation start
    output logic               flash_done    // Operation finished
);
    logic [23:0] word;
    int          cnt = 0;
    // Distinct 24-bit word per address in user and configuration space
    assign word       = {prog_out.addr[23:16] ^ 8'hC3, prog_out.addr[15:0] ^ 16'h3C5A};
    // Off the strobe the data turns over so stale reads show
    assign prog_rdata = prog_out.rd_en ? word : ~word;
    // Finish an operation a fixed delay after its start
    always @(posedge core_clk) begin
        if (flash_start) cnt <= DONE_DLY;
        else if (cnt > 0) cnt <= cnt - 1;
    end
    assign flash_done = (cnt == 1);
endmodule // psam_flash_model
`default_nettype wire

/* File: tb/psam_sva.sv */
// Port assertions for the program space mapper
`timescale 1ns/1ps
`default_nettype none
module psam_sva
    import psam_pkg::*;
#(
    parameter int PC_W = 23                  // Program counter width
) (
    input wire logic            core_clk,    // Clock
    input wire logic            rst_b,       // Reset, active low
    input wire logic [PC_W-1:0] fetch_pc,    // Program counter
    input wire logic [23:0]     fetch_addr,  // Fetch address
    input wire psam_req_type    core_req,    // Data-space request
    input wire psam_prog_type   prog_out,    // Program read port
    input wire logic [23:0]     prog_rdata,  // Program word
    input wire psam_latch_type  latch_out,   // Latch write
    input wire psam_dmem_type   dmem_out,    // Data memory access
    input wire logic            rsp_valid,   // Answer valid
    input wire logic [15:0]     rsp_data     // Answer
);
    // One domain: a request only counts when reset was already off
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    chk_fetch_form: assert property (
        $past(rst_b) |-> fetch_addr == {1'b0, $past(fetch_pc[22:1]), 1'b0})
        else $error("fetch address malformed");
    chk_table_addr: assert property (
        $past(rst_b && core_req.valid && core_req.op == PSAM_OP_TRD_L) |-> prog_out.rd_en
        && prog_out.addr[15:0] == $past(core_req.ea) && prog_out.cfg_sel == prog_out.addr[23])
        else $error("table read address wrong");
    chk_window_addr: assert property (
        $past(rst_b && core_req.valid && core_req.op == PSAM_OP_DATA && core_req.ea[15]
        && !core_req.write) |-> prog_out.rd_en && !prog_out.cfg_sel && !prog_out.addr[23]
        && prog_out.addr[14:0] == $past(core_req.ea[14:0])) else $error("window address wrong");
    chk_window_ro: assert property (
        $past(rst_b && core_req.valid && core_req.op == PSAM_OP_DATA && core_req.ea[15]
        && core_req.write) |-> !prog_out.rd_en && !dmem_out.en) else $error("window write passed");
    chk_window_word: assert property (
        $past(rst_b && core_req.valid && core_req.op == PSAM_OP_DATA && core_req.ea[15]
        && !core_req.write, 2) && $past(rst_b) |-> rsp_valid
        && rsp_data == $past(prog_rdata[15:0])) else $error("window answer wrong");
    chk_plain_data: assert property (
        $past(rst_b && core_req.valid && core_req.op == PSAM_OP_DATA && !core_req.ea[15])
        |-> dmem_out.en && dmem_out.addr == $past(core_req.ea) && !prog_out.rd_en)
        else $error("plain data access redirected");
    chk_file_near: assert property (
        $past(rst_b && core_req.valid && core_req.op == PSAM_OP_FILE) |-> dmem_out.en
        && dmem_out.addr == {3'h0, $past(core_req.ea[12:0])}) else $error("file address wrong");
    chk_low_latch: assert property (
        $past(rst_b && core_req.valid && core_req.op == PSAM_OP_TWR_L && !core_req.byte_mode)
        |-> latch_out.be == 3'h3 && latch_out.data[15:0] == $past(core_req.wdata))
        else $error("low latch write wrong");
    chk_high_latch: assert property (
        $past(rst_b && core_req.valid && core_req.op == PSAM_OP_TWR_H && !core_req.byte_mode)
        |-> latch_out.be == 3'h4 && latch_out.data[23:16] == $past(core_req.wdata[7:0]))
        else $error("high latch write wrong");
endmodule // psam_sva

bind psam_top psam_sva #(.PC_W(PC_W)) u_sva (.core_clk, .rst_b, .fetch_pc, .fetch_addr,
    .core_req, .prog_out, .prog_rdata, .latch_out, .dmem_out, .rsp_valid, .rsp_data);
`default_nettype wire

/* File: tb/psam_top_tb.sv */
// Self-checking bench for the program space mapper
`timescale 1ns/1ps
`default_nettype none
`include "psam_defs.svh"
module psam_top_tb
    import psam_pkg::*;
;
    logic           core_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]    paddr = 12'h000;
    logic [31:0]    pwdata = 32'h0, prdata, rv;
    logic           pready, pslverr, re, fetch_valid = 1'b0, fetch_rd_en, rsp_valid;
    logic           flash_start, flash_done;
    logic [22:0]    fetch_pc = 23'h0;
    logic [23:0]    fetch_addr, prog_rdata;
    logic [15:0]    rsp_data;
    logic [7:0]     tp = 8'h00, vp = 8'h00;
    psam_req_type   core_req = '0;
    psam_prog_type  prog_out;
    psam_latch_type latch_out, lat_q[$];
    psam_dmem_type  dmem_out;
    logic [24:0]    prg_q[$];
    logic [23:0]    fch_q[$];
    logic [15:0]    exp_q[$];
    int             n_errors = 0, check_count = 0, n_start = 0;

    psam_top #(.PC_W(23)) DUT (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .fetch_valid, .fetch_pc, .fetch_addr, .fetch_rd_en,
        .core_req, .prog_out, .prog_rdata, .latch_out, .dmem_out, .rsp_valid, .rsp_data,
        .flash_start, .flash_done);
    psam_flash_model #(.DONE_DLY(20)) u_flash (.core_clk, .prog_out, .prog_rdata,
        .flash_start, .flash_done);

    // Clock and watchdog
    initial forever #50 core_clk = ~core_clk;
    initial begin
        #500000;
        n_errors++;
        $display("timeout");
        test_done();
    end

    task check(input logic [63:0] s, input logic [63:0] x);
        check_count++;
        if (s !== x) begin
            n_errors++;
            $display("wrong value at %0t: %h vs %h", $time, s, x);
        end
    endtask

    // APB transfer: setup, access until pready, release after that edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge core_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // Ready, read data and error are taken at the edge that completes the access
        do begin
            @(posedge core_clk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        rv = prdata;
        re = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (t >= 20) n_errors++;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        check(64'(rv), 64'(x));
    endtask

    // One core request per edge; expectations go to the queues
    task op(input psam_op_type o, input logic [15:0] e, input logic [15:0] d, input logic w,
            input logic bm);
        logic [23:0] ta, va, p, pv;
        logic        fv;
        logic [22:0] pc;
        ta = {tp, e};
        va = {1'b0, vp, e[14:0]};
        p  = {ta[23:16] ^ 8'hC3, ta[15:0] ^ 16'h3C5A};
        pv = {va[23:16] ^ 8'hC3, va[15:0] ^ 16'h3C5A};
        fv = 1'($urandom);
        pc = 23'($urandom);
        @(posedge core_clk);
        core_req <= '{1'b1, o, w, bm, e, d};
        fetch_valid <= fv;
        fetch_pc <= pc;
        if (fv) fch_q.push_back({1'b0, pc[22:1], 1'b0});
        case (o)
            PSAM_OP_TRD_L: begin
                prg_q.push_back({tp[7], ta});
                exp_q.push_back(bm ? {8'h00, e[0] ? p[15:8] : p[7:0]} : p[15:0]);
            end
            PSAM_OP_TRD_H: begin
                prg_q.push_back({tp[7], ta});
                exp_q.push_back((bm && e[0]) ? 16'h0000 : {8'h00, p[23:16]});
            end
            PSAM_OP_TWR_L: begin
                if (bm) lat_q.push_back({e[0] ? 3'h2 : 3'h1, ta, 8'h00, d[7:0], d[7:0]});
                else lat_q.push_back({3'h3, ta, 8'h00, d});
            end
            PSAM_OP_TWR_H: if (!(bm && e[0])) lat_q.push_back({3'h4, ta, d[7:0], 16'h0000});
            PSAM_OP_DATA: if (e[15] && !w) begin
                prg_q.push_back({1'b0, va});
                exp_q.push_back(pv[15:0]);
            end
            default: ;
        endcase
    endtask

    // Result watcher: oldest note against each answer
    always @(negedge core_clk) begin
        if (rst_b) begin
            if (rsp_valid === 1'b1) check(64'(rsp_data), 64'(exp_q.pop_front()));
            if (prog_out.rd_en === 1'b1) check(64'(prog_out[24:0]), 64'(prg_q.pop_front()));
            if (latch_out.be !== 3'h0) check(64'(latch_out), 64'(lat_q.pop_front()));
            if (fetch_rd_en === 1'b1) check(64'(fetch_addr), 64'(fch_q.pop_front()));
            if (flash_start === 1'b1) n_start++;
        end
    end

    initial begin
        psam_op_type o;
        void'($urandom(87));
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(`PSAM_OFS_TBL_PAGE, 32'h0);
        rd(`PSAM_OFS_VIS_PAGE, 32'h0);
        rd(12'h020, 32'h0);
        check(64'(re), 64'h1);
        $display("test registers done");
        // Two page settings, user then configuration, random ops back to back
        for (int k = 0; k < 2; k++) begin
            tp = {k[0], 7'($urandom)};
            vp = 8'($urandom);
            apb(1'b1, `PSAM_OFS_TBL_PAGE, 32'(tp));
            apb(1'b1, `PSAM_OFS_VIS_PAGE, 32'(vp));
            rd(`PSAM_OFS_TBL_PAGE, 32'(tp));
            repeat (40) begin
                o = psam_op_type'(3'($urandom_range(5)));
                op(o, 16'($urandom), 16'($urandom),
                   o >= PSAM_OP_TWR_L || (o == PSAM_OP_DATA && 1'($urandom)),
                   o >= PSAM_OP_TRD_L && 1'($urandom));
            end
            op(PSAM_OP_DATA, 16'h8000, 16'h1234, 1'b1, 1'b0);
            @(posedge core_clk);
            core_req.valid <= 1'b0;
            fetch_valid <= 1'b0;
        end
        $display("test mapping done");
        // Start with half a key is refused, then the full sequence starts once
        apb(1'b1, `PSAM_OFS_KEY, 32'h55);
        apb(1'b1, `PSAM_OFS_CTL, 32'h1);
        rd(`PSAM_OFS_STAT, 32'h3);
        apb(1'b1, `PSAM_OFS_STAT, 32'h3);
        rd(`PSAM_OFS_STAT, 32'h0);
        apb(1'b1, `PSAM_OFS_KEY, 32'h55);
        apb(1'b1, `PSAM_OFS_KEY, 32'hAA);
        rd(`PSAM_OFS_CTL, 32'h2);
        apb(1'b1, `PSAM_OFS_CTL, 32'h1);
        repeat (2) @(posedge core_clk);
        rd(`PSAM_OFS_CTL, 32'h1);
        repeat (30) @(posedge core_clk);
        rd(`PSAM_OFS_CTL, 32'h0);
        check(64'(n_start), 64'h1);
        check(64'(exp_q.size() + prg_q.size() + lat_q.size() + fch_q.size()), 64'h0);
        $display("test unlock done");
        test_done();
    end

    task test_done;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
endmodule // psam_top_tb
`default_nettype wire
